// *** hw/tec_channel.sv ***
// tec_channel: one 16-bit timer channel in event counter mode
// assumes pins and neighbour wrap pulses are synchronous-capable inputs on clock
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tec_channel #(
    parameter int CHANNEL = 2
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [15:0]      reg_rdata,
    input  wire logic        count_input_pin,
    input  wire logic        timer_output_pin_in,
    output logic             timer_output_pin_out,
    output logic             timer_output_pin_oe,
    input  wire logic        b2_wrap,
    input  wire logic        prev_wrap,
    input  wire logic        next_wrap,
    output logic             wrap_pulse,
    output logic             irq
);
    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    tec_pkg::tec_req_t req;
    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    logic [15:0]         count_q;
    logic [15:0]         count_d;
    logic [15:0]         reload_q;
    logic [5:0]          mode_q;
    logic                channel_run_bit_q;
    logic [1:0]          trigger_select_q;
    logic [1:0]          status_q;
    logic [1:0]          status_d;
    logic [1:0]          mask_q;
    logic                pulse_q;
    logic [15:0]         rdata_q;
    tec_pkg::tec_state_t state_q;
    tec_pkg::tec_state_t state_d;

    wire sel_count  = req.addr == tec_pkg::ADDR_COUNT;
    wire sel_mode   = req.addr == tec_pkg::ADDR_MODE;
    wire sel_start  = req.addr == tec_pkg::ADDR_START;
    wire sel_trig   = req.addr == tec_pkg::ADDR_TRIG;
    wire sel_status = req.addr == tec_pkg::ADDR_STATUS;
    wire sel_mask   = req.addr == tec_pkg::ADDR_MASK;
    wire sel_state  = req.addr == tec_pkg::ADDR_STATE;
    wire wr_count   = req.wr && sel_count;

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    wire two_phase_ok = (CHANNEL >= 2) && (CHANNEL <= 4);
    wire mode_pulse   = mode_q[tec_pkg::MODE_PULSE_BIT];
    wire mode_free    = mode_q[tec_pkg::MODE_FREE_BIT];
    wire mode_extdir  = mode_q[tec_pkg::MODE_EXTDIR_BIT];
    wire mode_up      = mode_q[tec_pkg::MODE_UP_BIT];
    wire mode_fall    = mode_q[tec_pkg::MODE_FALL_BIT];
    wire mode_twoph   = mode_q[tec_pkg::MODE_TWOPH_BIT] && two_phase_ok;
    // output pin is an input when used for direction or second phase
    wire pin_as_input = mode_extdir || mode_twoph;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [1:0] cin_sync_q;
    logic [1:0] dir_sync_q;
    logic       cin_prev_q;
    logic       dir_prev_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cin_sync_q <= 2'h0;
            dir_sync_q <= 2'h0;
            cin_prev_q <= 1'b0;
            dir_prev_q <= 1'b0;
        end else begin
            cin_sync_q <= {cin_sync_q[0], count_input_pin};
            dir_sync_q <= {dir_sync_q[0], timer_output_pin_in};
            cin_prev_q <= cin_sync_q[1];
            dir_prev_q <= dir_sync_q[1];
        end
    end

    wire cin_s   = cin_sync_q[1];
    wire dir_s   = dir_sync_q[1];
    wire cin_rise = cin_s && !cin_prev_q;
    wire cin_fall = !cin_s && cin_prev_q;
    wire dir_rise = dir_s && !dir_prev_q;
    wire dir_fall = !dir_s && dir_prev_q;

    // ------------------------------------------------------------
    // count source selection
    // ------------------------------------------------------------
    wire pin_edge   = mode_fall ? cin_fall : cin_rise;
    wire single_evt = (trigger_select_q == tec_pkg::TRIG_PIN)  ? pin_edge :
                      (trigger_select_q == tec_pkg::TRIG_B2)   ? b2_wrap :
                      (trigger_select_q == tec_pkg::TRIG_PREV) ? prev_wrap :
                                                                 next_wrap;
    wire single_up  = mode_extdir ? dir_s : mode_up;

    // two-phase: a leads b counts up, b leads a counts down
    wire ph_a_edge = cin_rise || cin_fall;
    wire ph_b_edge = dir_rise || dir_fall;
    wire ph_evt    = ph_a_edge || ph_b_edge;
    wire ph_up     = ph_a_edge ? (cin_s != dir_s) : (cin_s == dir_s);

    wire evt    = mode_twoph ? ph_evt : single_evt;
    wire cnt_up = mode_twoph ? ph_up : single_up;

    // ------------------------------------------------------------
    // counter state machine
    // ------------------------------------------------------------
    wire running  = state_q != tec_pkg::TEC_IDLE;
    wire step     = running && evt;
    wire at_limit = cnt_up ? (count_q == tec_pkg::COUNT_MAX) : (count_q == tec_pkg::COUNT_RST);
    wire wrap     = step && at_limit;
    wire [15:0] stepped = cnt_up ? 16'(count_q + 16'h0001) : 16'(count_q - 16'h0001);
    wire run_wr   = req.wr && sel_start;

    always_comb begin
        state_d = state_q;
        case (state_q)
            tec_pkg::TEC_IDLE: begin
                if (run_wr && req.wdata[0]) begin
                    state_d = tec_pkg::TEC_ARMED;
                end
            end
            tec_pkg::TEC_ARMED: begin
                if (run_wr && !req.wdata[0]) begin
                    state_d = tec_pkg::TEC_IDLE;
                end else if (evt) begin
                    state_d = tec_pkg::TEC_COUNTING;
                end
            end
            tec_pkg::TEC_COUNTING: begin
                if (run_wr && !req.wdata[0]) begin
                    state_d = tec_pkg::TEC_IDLE;
                end
            end
            default: state_d = tec_pkg::TEC_IDLE;
        endcase
    end

    always_comb begin
        count_d = count_q;
        if (step) begin
            if (wrap && !mode_free) begin
                count_d = reload_q;
            end else begin
                count_d = stepped;
            end
        end
        if (wr_count && state_q != tec_pkg::TEC_COUNTING && !step) begin
            count_d = req.wdata;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q  <= tec_pkg::TEC_IDLE;
            count_q  <= tec_pkg::COUNT_RST;
            reload_q <= tec_pkg::COUNT_RST;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
            if (wr_count) begin
                reload_q <= req.wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_q            <= tec_pkg::MODE_RST;
            channel_run_bit_q <= 1'b0;
            trigger_select_q  <= tec_pkg::TRIG_PIN;
            mask_q            <= 2'h0;
        end else begin
            if (req.wr && sel_mode) begin
                mode_q <= req.wdata[5:0];
            end
            if (run_wr) begin
                channel_run_bit_q <= req.wdata[0];
            end
            if (req.wr && sel_trig) begin
                trigger_select_q <= req.wdata[1:0];
            end
            if (req.wr && sel_mask) begin
                mask_q <= req.wdata[1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt status, write one to clear, set wins
    // ------------------------------------------------------------
    wire [1:0] status_set = {step && state_q == tec_pkg::TEC_ARMED, wrap};
    wire [1:0] status_clr = (req.wr && sel_status) ? req.wdata[1:0] : 2'h0;

    always_comb begin
        status_d = (status_q & ~status_clr) | status_set;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            status_q <= 2'h0;
        end else begin
            status_q <= status_d;
        end
    end

    assign irq        = |(status_q & mask_q);
    assign wrap_pulse = wrap;

    // ------------------------------------------------------------
    // pulse output
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pulse_q <= 1'b0;
        end else if (!running) begin
            pulse_q <= 1'b0;
        end else if (wrap) begin
            pulse_q <= !pulse_q;
        end
    end

    assign timer_output_pin_out = pulse_q;
    assign timer_output_pin_oe  = mode_pulse && !pin_as_input;

    // ------------------------------------------------------------
    // read data, one cycle after the strobe
    // ------------------------------------------------------------
    wire [15:0] rd_mux =
        sel_count  ? count_q :
        sel_mode   ? {10'h000, mode_q} :
        sel_start  ? {15'h0000, channel_run_bit_q} :
        sel_trig   ? {14'h0000, trigger_select_q} :
        sel_status ? {14'h0000, status_q} :
        sel_mask   ? {14'h0000, mask_q} :
        sel_state  ? {14'h0000, state_q} :
                     16'h0000;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_q <= 16'h0000;
        end else if (req.rd) begin
            rdata_q <= rd_mux;
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    assign reg_rdata = rdata_q;
endmodule
`default_nettype wire

// *** hw/tec_pkg.sv ***
// tec_pkg: constants and types for the timer event counter channel
// assumes a single 200 MHz system clock domain
package tec_pkg;
    // ------------------------------------------------------------
    // register map (word index on the plain register port)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_COUNT  = 4'h0;
    localparam logic [3:0] ADDR_MODE   = 4'h1;
    localparam logic [3:0] ADDR_START  = 4'h2;
    localparam logic [3:0] ADDR_TRIG   = 4'h3;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_MASK   = 4'h5;
    localparam logic [3:0] ADDR_STATE  = 4'h6;
    // ------------------------------------------------------------
    // mode register fields
    // ------------------------------------------------------------
    localparam int MODE_PULSE_BIT  = 0;
    localparam int MODE_FREE_BIT   = 1;
    localparam int MODE_EXTDIR_BIT = 2;
    localparam int MODE_UP_BIT     = 3;
    localparam int MODE_FALL_BIT   = 4;
    localparam int MODE_TWOPH_BIT  = 5;
    localparam logic [5:0] MODE_RST = 6'h00;
    // ------------------------------------------------------------
    // trigger select codes
    // ------------------------------------------------------------
    localparam logic [1:0] TRIG_PIN  = 2'h0;
    localparam logic [1:0] TRIG_B2   = 2'h1;
    localparam logic [1:0] TRIG_PREV = 2'h2;
    localparam logic [1:0] TRIG_NEXT = 2'h3;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    // status bit positions
    localparam int STAT_WRAP_BIT = 0;
    localparam int STAT_EDGE_BIT = 1;

    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } tec_req_t;

    typedef enum logic [1:0] {
        TEC_IDLE,
        TEC_ARMED,
        TEC_COUNTING
    } tec_state_t;
endpackage

// *** testbench/tec_channel_checker.sv ***
// tec_channel_checker: port-level checks of the event counter channel
// assumes it is bound onto tec_channel, one clock domain
`timescale 1ns/1ps
`default_nettype none
module tec_channel_checker #(
    parameter int CHANNEL = 2
) (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic [3:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        count_input_pin,
    input wire logic        timer_output_pin_in,
    input wire logic        timer_output_pin_out,
    input wire logic        timer_output_pin_oe,
    input wire logic        b2_wrap,
    input wire logic        prev_wrap,
    input wire logic        next_wrap,
    input wire logic        wrap_pulse,
    input wire logic        irq
);
    logic [5:0] mode_q;
    logic [1:0] trig_q;
    logic       run_q;
    logic       mask_q;
    wire logic  wr_mask = reg_wr && reg_addr == tec_pkg::ADDR_MASK;
    wire logic  two_ok = CHANNEL >= 2 && CHANNEL <= 4;

    // shadow of the control registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_q <= 6'h00;
            trig_q <= 2'h0;
            run_q  <= 1'b0;
            mask_q <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == tec_pkg::ADDR_MODE) mode_q <= reg_wdata[5:0];
            if (reg_addr == tec_pkg::ADDR_TRIG) trig_q <= reg_wdata[1:0];
            if (reg_addr == tec_pkg::ADDR_START) run_q <= reg_wdata[0];
            if (wr_mask) mask_q <= reg_wdata[0];
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_pin_quiet;
        $stable(count_input_pin) [*6];
    endsequence
    sequence s_wrap_seen;
        wrap_pulse && mask_q && !wr_mask;
    endsequence

    a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside the answer cycle");
    a_unmapped_read: assert property (reg_rd && reg_addr > tec_pkg::ADDR_STATE |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_stop_no_wrap: assert property (!run_q |-> !wrap_pulse)
        else $error("wrap while stopped");
    a_wrap_irq: assert property (s_wrap_seen |=> irq)
        else $error("no interrupt after unmasked wrap");
    a_out_idle_low: assert property (!run_q [*2] |-> !timer_output_pin_out)
        else $error("pulse output high while stopped");
    a_out_toggle: assert property (wrap_pulse && timer_output_pin_oe && !reg_wr
        |=> timer_output_pin_out != $past(timer_output_pin_out))
        else $error("pulse output did not toggle");
    a_pulse_drive: assert property (mode_q[0] && !mode_q[2] && !mode_q[5] |-> timer_output_pin_oe)
        else $error("pulse output not driven");
    a_dir_pin_input: assert property (mode_q[2] |-> !timer_output_pin_oe)
        else $error("direction pin driven");
    a_phase_input: assert property (mode_q[5] && two_ok |-> !timer_output_pin_oe)
        else $error("phase pin driven");
    a_pin_sync: assert property (s_pin_quiet ##0 (trig_q == tec_pkg::TRIG_PIN && !mode_q[5])
        |-> !wrap_pulse)
        else $error("wrap without a synchronised pin edge");
endmodule
bind tec_channel tec_channel_checker #(.CHANNEL(CHANNEL)) chk_u (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .count_input_pin(count_input_pin),
    .timer_output_pin_in(timer_output_pin_in), .timer_output_pin_out(timer_output_pin_out),
    .timer_output_pin_oe(timer_output_pin_oe), .b2_wrap(b2_wrap), .prev_wrap(prev_wrap),
    .next_wrap(next_wrap), .wrap_pulse(wrap_pulse), .irq(irq)
);
`default_nettype wire

// *** testbench/tec_pulse_src.sv ***
// tec_pulse_src: external pulse source and neighbour timers
// assumes the bench resolves the shared output pin
`timescale 1ns/1ps
`default_nettype none
module tec_pulse_src (
    input wire logic clock,
    output logic     pin_a,
    output logic     pin_b,
    output logic     pin_b_oe,
    output logic     b2_wrap,
    output logic     prev_wrap,
    output logic     next_wrap
);
    initial begin
        {pin_a, pin_b, pin_b_oe, b2_wrap, prev_wrap, next_wrap} = 6'h00;
    end
    // one event: 0 phase a, 1 phase b, 2 b2, 3 previous, 4 next
    task automatic ev(input int k, input int gap);
        @(posedge clock);
        case (k)
            0: pin_a <= ~pin_a;
            1: pin_b <= ~pin_b;
            2: b2_wrap <= 1'b1;
            3: prev_wrap <= 1'b1;
            default: next_wrap <= 1'b1;
        endcase
        @(posedge clock);
        {b2_wrap, prev_wrap, next_wrap} <= 3'h0;
        repeat (gap) @(posedge clock);
    endtask
    // drive the direction pin from the next clock, without waiting for the channel to release it
    task automatic drive_b(input logic en, input logic lvl);
        @(posedge clock);
        pin_b_oe <= en;
        pin_b <= lvl;
    endtask
endmodule
`default_nettype wire

// *** testbench/tec_channel_tb_top.sv ***
// tec_channel_tb_top: self-checking bench of the event counter channel
// assumes tec_pkg, tec_channel, the bound checker and tec_pulse_src
`timescale 1ns/1ps
`default_nettype none
module tec_channel_tb_top;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_rdata, v;
    logic        pin_a, src_b, src_b_oe, out, oe, b2, prv, nxt, wrap, irq;
    logic        b_last_q = 1'b0;
    logic        rd_pend = 1'b0;
    logic [15:0] exp_q[$];
    int          miscompares = 0;
    int          checks = 0;
    int          seed = 32'ha5956189;
    // released pin shows the inverse of its last level
    wire logic   pin_b_lvl = oe ? out : (src_b_oe ? src_b : ~b_last_q);

    tec_channel #(.CHANNEL(2)) dut_u (
        .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .count_input_pin(pin_a), .timer_output_pin_in(pin_b_lvl),
        .timer_output_pin_out(out), .timer_output_pin_oe(oe), .b2_wrap(b2), .prev_wrap(prv),
        .next_wrap(nxt), .wrap_pulse(wrap), .irq(irq));
    tec_pulse_src src_u (.clock(clock), .pin_a(pin_a), .pin_b(src_b), .pin_b_oe(src_b_oe),
        .b2_wrap(b2), .prev_wrap(prv), .next_wrap(nxt));

    initial begin
        forever #2.5 clock = ~clock;
    end
    always @(posedge clock) begin
        if (oe || src_b_oe) b_last_q <= pin_b_lvl;
        if (rd_pend) chk("reg_rdata", exp_q.pop_front(), reg_rdata);
        rd_pend <= reg_rd;
    end

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
    endtask
    task automatic pulse(input int gap);
        src_u.ev(0, gap);
        src_u.ev(0, gap);
    endtask
    task automatic stop_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        stop_test();
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        rd(tec_pkg::ADDR_COUNT, tec_pkg::COUNT_RST);
        rd(tec_pkg::ADDR_MODE, {10'h000, tec_pkg::MODE_RST});
        rd(4'hf, 16'h0000);
        wr(tec_pkg::ADDR_MASK, 16'h0001);
        for (int i = 0; i < 3; i++) begin
            v = 16'($random(seed));
            wr(tec_pkg::ADDR_COUNT, v);
            rd(tec_pkg::ADDR_COUNT, v);
        end
        // up count on rising pin edges, reload on overflow
        wr(tec_pkg::ADDR_MODE, 16'h0008);
        wr(tec_pkg::ADDR_COUNT, 16'hfffc);
        wr(tec_pkg::ADDR_START, 16'h0001);
        pulse(4);
        rd(tec_pkg::ADDR_COUNT, 16'hfffd);
        wr(tec_pkg::ADDR_COUNT, 16'hfff0);
        rd(tec_pkg::ADDR_COUNT, 16'hfffd);
        repeat (3) pulse(9);
        rd(tec_pkg::ADDR_COUNT, 16'hfff0);
        rd(tec_pkg::ADDR_STATUS, 16'h0003);
        wr(tec_pkg::ADDR_STATUS, 16'h0003);
        rd(tec_pkg::ADDR_STATUS, 16'h0000);
        // neighbour sources, free-run down count with pulse output
        for (int t = 1; t < 4; t++) begin
            wr(tec_pkg::ADDR_START, 16'h0000);
            @(posedge clock);
            #1 chk("pin_out", 16'h0000, {15'h0000, out});
            wr(tec_pkg::ADDR_MODE, 16'h0003);
            wr(tec_pkg::ADDR_TRIG, 16'(t));
            wr(tec_pkg::ADDR_COUNT, 16'h0001);
            wr(tec_pkg::ADDR_START, 16'h0001);
            pulse(4);
            for (int k = 2; k < 5; k++)
                if (k != t + 1) src_u.ev(k, 2);
            rd(tec_pkg::ADDR_COUNT, 16'h0001);
            src_u.ev(t + 1, 0);
            src_u.ev(t + 1, 3);
            rd(tec_pkg::ADDR_COUNT, 16'hffff);
            #1 chk("pin_out", 16'h0001, {15'h0000, out});
        end
        #1 chk("irq", 16'h0001, {15'h0000, irq});
        wr(tec_pkg::ADDR_MASK, 16'h0000);
        #1 chk("irq", 16'h0000, {15'h0000, irq});
        // direction from the output pin
        wr(tec_pkg::ADDR_START, 16'h0000);
        wr(tec_pkg::ADDR_TRIG, 16'h0000);
        wr(tec_pkg::ADDR_MODE, 16'h0004);
        src_u.drive_b(1'b1, 1'b1);
        wr(tec_pkg::ADDR_COUNT, 16'h0005);
        wr(tec_pkg::ADDR_START, 16'h0001);
        pulse(4);
        rd(tec_pkg::ADDR_COUNT, 16'h0006);
        src_u.drive_b(1'b1, 1'b0);
        repeat (4) @(posedge clock);
        pulse(4);
        rd(tec_pkg::ADDR_COUNT, 16'h0005);
        #1 chk("pin_oe", 16'h0000, {15'h0000, oe});
        // two-phase: up sequence then down sequence
        wr(tec_pkg::ADDR_START, 16'h0000);
        wr(tec_pkg::ADDR_MODE, 16'h0020);
        wr(tec_pkg::ADDR_COUNT, 16'h000a);
        wr(tec_pkg::ADDR_START, 16'h0001);
        for (int d = 0; d < 2; d++) begin
            for (int s = 0; s < 4; s++)
                src_u.ev(d ^ (s % 2), 3 + 5 * d);
            rd(tec_pkg::ADDR_COUNT, d ? 16'h000a : 16'h000e);
        end
        repeat (4) @(posedge clock);
        stop_test();
    end
endmodule
`default_nettype wire
